// [pst_pkg.sv]
// What this block does
// R1: drop leading space-select nibble from register index
// R2: status bit 11 reads one, maintenance channel
// R3: status bit 10 reads zero, no efficient mode
// R4: status bit 9 reads zero, no fault detect
// R5: status bit 8 reads one, low power supported
// R6: status bit 2 shows receive polarity inverted
// R7: status bit 1 shows receive fault present
// R8: status bit 0 shows receive link, resets zero
// R9: training bits 10..4 hold writable user field
// R10: training bit 1 enables maintenance advertise, resets one
// R11: training bit 0 enables efficient advertise, resets zero
// R12: reserved bits read zero, writes ignored
// R13: link bit latches low until status read
package pst_pkg;

    // ----------------------------------------------------------------
    // bus geometry
    // ----------------------------------------------------------------
    localparam int WB_AW   = 14;     // byte address width
    localparam int WB_DW   = 32;     // bus data width
    localparam int WB_SW   = 4;      // byte lane selects
    localparam int REG_W   = 16;     // register width, low bits of the word
    localparam int IDX_W   = 12;     // index width once the space nibble is gone
    localparam int IDX_LSB = 2;      // word aligned: byte address is four times index
    localparam int LANE_W  = 8;      // bits per byte lane

    // ----------------------------------------------------------------
    // register indices, as printed, space nibble included
    // ----------------------------------------------------------------
    localparam logic [15:0] IDX_MEDIUM_STATUS = 16'h1901;
    localparam logic [15:0] IDX_TRAINING      = 16'h1902;
    localparam logic [15:0] IDX_IRQ_STATUS    = 16'h1910;
    localparam logic [15:0] IDX_IRQ_MASK      = 16'h1911;

    // ----------------------------------------------------------------
    // medium attach status layout
    // ----------------------------------------------------------------
    localparam int ST_OAM_BIT   = 11;
    localparam int ST_EEE_BIT   = 10;
    localparam int ST_RXFA_BIT  = 9;
    localparam int ST_LP_BIT    = 8;
    localparam int ST_POL_BIT   = 2;
    localparam int ST_FAULT_BIT = 1;
    localparam int ST_LINK_BIT  = 0;
    localparam logic CAP_OAM  = 1'b1;  // maintenance channel present
    localparam logic CAP_EEE  = 1'b0;  // efficient mode absent
    localparam logic CAP_RXFA = 1'b0;  // fault detection ability absent
    localparam logic CAP_LP   = 1'b1;  // low power present
    localparam logic [REG_W-1:0] ST_RESET = 16'h0900;

    // ----------------------------------------------------------------
    // training advertise layout
    // ----------------------------------------------------------------
    localparam int TR_USER_LSB = 4;
    localparam int TR_USER_W   = 7;
    localparam int TR_OAM_BIT  = 1;
    localparam int TR_EEE_BIT  = 0;
    localparam logic [REG_W-1:0] TR_RESET = 16'h0002;
    localparam logic [REG_W-1:0] TR_WMASK = 16'h07F3;  // writable bits only

    // ----------------------------------------------------------------
    // interrupt status and mask layout
    // ----------------------------------------------------------------
    localparam int IRQ_W         = 3;
    localparam int IRQ_LINK_DROP = 0;
    localparam int IRQ_FAULT_SET = 1;
    localparam int IRQ_POL_CHG   = 2;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

    localparam int SYNC_STAGES = 2;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,   // waiting for a request
        BUS_ACK  = 1'b1    // ack high for one cycle
    } pst_bus_st_t;

    typedef struct packed {
        logic link_up;     // receive link up
        logic rx_fault;    // receive fault seen
        logic rx_pol_inv;  // receive pair polarity inverted
    } pst_line_t;

    typedef struct packed {
        logic [TR_USER_W-1:0] user;    // user field sent during training
        logic                 oam_en;  // advertise maintenance channel
        logic                 eee_en;  // advertise efficient mode
    } pst_adv_t;

endpackage

// [pst_regs.sv]
// Local design decision: the Wishbone register port.
`timescale 1ns/100ps
module pst_regs
    import pst_pkg::*;
(
    input  wire logic             mclk,
    input  wire logic             rstn,
    input  wire logic             ce,
    // classic wishbone slave
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [WB_AW-1:0] wb_adr_i,
    input  wire logic [WB_SW-1:0] wb_sel_i,
    input  wire logic [WB_DW-1:0] wb_dat_i,
    output logic      [WB_DW-1:0] wb_dat_o,
    output logic                  wb_ack_o,
    // line state from the receive side, asynchronous
    input  wire pst_line_t        line_i,
    // values advertised during training
    output pst_adv_t              adv_o,
    // level interrupt
    output logic                  irq_o
);

    // ----------------------------------------------------------------
    // local indices with the space nibble stripped
    // ----------------------------------------------------------------
    localparam logic [IDX_W-1:0] LIDX_STATUS = IDX_MEDIUM_STATUS[IDX_W-1:0];  // R1
    localparam logic [IDX_W-1:0] LIDX_TRAIN  = IDX_TRAINING[IDX_W-1:0];       // R1
    localparam logic [IDX_W-1:0] LIDX_ISTAT  = IDX_IRQ_STATUS[IDX_W-1:0];     // R1
    localparam logic [IDX_W-1:0] LIDX_IMASK  = IDX_IRQ_MASK[IDX_W-1:0];       // R1

    // ----------------------------------------------------------------
    // module state
    // ----------------------------------------------------------------
    typedef struct packed {
        pst_bus_st_t      bus;         // bus handshake phase
        logic [WB_DW-1:0] rdat;        // read data held for the ack cycle
        logic [REG_W-1:0] train;       // training advertise contents
        logic             link_lat;    // latched-low receive link
        logic [IRQ_W-1:0] mask;        // interrupt enables
        logic             link_prev;   // last link level, for drop events
        logic             fault_prev;  // last fault level, for rise events
        logic             pol_prev;    // last polarity level, for change events
    } pst_regs_st_t;

    pst_regs_st_t q;
    pst_regs_st_t d;

    // ----------------------------------------------------------------
    // receive line synchronisers
    // ----------------------------------------------------------------
    pst_line_t line_s;        // settled copies of the line inputs

    pst_sync #(
        .W ($bits(pst_line_t))
    ) u_sync (
        .mclk    (mclk),
        .rstn    (rstn),
        .ce      (ce),
        .async_i (line_i),
        .sync_o  (line_s)
    );

    // ----------------------------------------------------------------
    // event detection and interrupt flags
    // ----------------------------------------------------------------
    logic [IRQ_W-1:0] ev_set;     // one-cycle events
    logic [IRQ_W-1:0] ev_clr;     // write-one-to-clear strobes
    logic [IRQ_W-1:0] irq_stat;   // sticky event flags

    // events come from the settled side only, never from stage one
    always_comb begin
        ev_set                = '0;
        ev_set[IRQ_LINK_DROP] = q.link_prev & ~line_s.link_up;
        ev_set[IRQ_FAULT_SET] = ~q.fault_prev & line_s.rx_fault;
        ev_set[IRQ_POL_CHG]   = q.pol_prev ^ line_s.rx_pol_inv;
    end

    pst_sticky #(
        .W (IRQ_W)
    ) u_sticky (
        .mclk   (mclk),
        .rstn   (rstn),
        .ce     (ce),
        .set_i  (ev_set),
        .clr_i  (ev_clr),
        .flag_o (irq_stat)
    );

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    logic             req;        // request present
    logic [IDX_W-1:0] idx;        // register index from the byte address
    logic             acc;        // access completes at this edge
    logic             wr_acc;     // completing write
    logic             rd_acc;     // completing read
    logic [REG_W-1:0] lane_m;     // bits covered by the byte selects
    logic [REG_W-1:0] st_val;     // medium attach status as read
    logic [REG_W-1:0] rd_val;     // selected register value

    assign req    = wb_cyc_i & wb_stb_i;
    assign idx    = wb_adr_i[WB_AW-1:IDX_LSB];  // R1
    assign acc    = req & (q.bus == BUS_ACK);
    assign wr_acc = acc & wb_we_i;
    assign rd_acc = acc & ~wb_we_i;
    assign lane_m = {{LANE_W{wb_sel_i[1]}}, {LANE_W{wb_sel_i[0]}}};

    // clear strobes only on the edge at which the write is taken
    always_comb begin
        ev_clr = '0;
        if (wr_acc && idx == LIDX_ISTAT && wb_sel_i[0]) begin
            ev_clr = wb_dat_i[IRQ_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // status word: fixed abilities, live polarity and fault, latched-low link
    // ----------------------------------------------------------------
    always_comb begin
        st_val               = '0;               // R12
        st_val[ST_OAM_BIT]   = CAP_OAM;          // R2
        st_val[ST_EEE_BIT]   = CAP_EEE;          // R3
        st_val[ST_RXFA_BIT]  = CAP_RXFA;         // R4
        st_val[ST_LP_BIT]    = CAP_LP;           // R5
        st_val[ST_POL_BIT]   = line_s.rx_pol_inv; // R6
        st_val[ST_FAULT_BIT] = line_s.rx_fault;  // R7
        st_val[ST_LINK_BIT]  = q.link_lat;       // R8
    end

    // ----------------------------------------------------------------
    // read multiplexer; unmapped indices answer with zero
    // ----------------------------------------------------------------
    always_comb begin
        rd_val = '0;
        unique case (idx)
            LIDX_STATUS: begin
                rd_val = st_val;
            end
            LIDX_TRAIN: begin
                rd_val = q.train & TR_WMASK;     // R12
            end
            LIDX_ISTAT: begin
                rd_val[IRQ_W-1:0] = irq_stat;
            end
            LIDX_IMASK: begin
                rd_val[IRQ_W-1:0] = q.mask;
            end
            default: begin
                rd_val = '0;                     // any other index is unmapped
            end
        endcase
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        d            = q;
        d.link_prev  = line_s.link_up;
        d.fault_prev = line_s.rx_fault;
        d.pol_prev   = line_s.rx_pol_inv;

        // handshake: one wait state, then ack for exactly one cycle
        unique case (q.bus)
            BUS_IDLE: begin
                if (req) begin
                    d.bus  = BUS_ACK;
                    d.rdat = {{(WB_DW-REG_W){1'b0}}, rd_val};  // R12
                end
            end
            BUS_ACK: begin
                d.bus = BUS_IDLE;
            end
        endcase

        // training advertise: only writable bits under a selected lane
        if (wr_acc && idx == LIDX_TRAIN) begin
            d.train = (q.train & ~(TR_WMASK & lane_m))
                    | (wb_dat_i[REG_W-1:0] & TR_WMASK & lane_m);  // R9 R10 R11 R12
        end

        // interrupt mask
        if (wr_acc && idx == LIDX_IMASK && wb_sel_i[0]) begin
            d.mask = wb_dat_i[IRQ_W-1:0];
        end

        // link bit stays low after a drop until software has read it;
        // a drop in the read cycle still lands because link is low then
        if (rd_acc && idx == LIDX_STATUS) begin
            d.link_lat = line_s.link_up;              // R13
        end else begin
            d.link_lat = q.link_lat & line_s.link_up; // R13
        end
    end

    // ----------------------------------------------------------------
    // state register, frozen while ce is low
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q            <= '0;
            q.bus        <= BUS_IDLE;
            q.train      <= TR_RESET;     // R9 R10 R11
            q.link_lat   <= ST_RESET[ST_LINK_BIT];  // R8
            q.mask       <= IRQ_RESET;
        end else if (ce) begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // ack is combinational so it falls as soon as the master lets go
    assign wb_ack_o = req & (q.bus == BUS_ACK);
    assign wb_dat_o = q.rdat;
    // one driver for the whole struct, fields in declaration order
    assign adv_o = {q.train[TR_USER_LSB +: TR_USER_W],  // R9
                    q.train[TR_OAM_BIT],                // R10
                    q.train[TR_EEE_BIT]};               // R11
    // level interrupt; stays up until every unmasked flag is cleared
    assign irq_o = |(irq_stat & q.mask);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    // a completing read of the status register
    sequence s_status_read;
        rd_acc && idx == LIDX_STATUS && $past(ce);
    endsequence

    // a completing read of the training register
    sequence s_train_read;
        rd_acc && idx == LIDX_TRAIN;
    endsequence

    // a full-lane write to training taken at this edge
    sequence s_train_write;
        ce && wr_acc && idx == LIDX_TRAIN && wb_sel_i[1] && wb_sel_i[0];
    endsequence

    property p_caps_one;
        @(posedge mclk) disable iff (!rstn)
        s_status_read |-> wb_dat_o[ST_OAM_BIT] && wb_dat_o[ST_LP_BIT];
    endproperty
    a_caps_one: assert property (p_caps_one) // R2 R5
        else $error("capability ones missing");

    property p_caps_zero;
        @(posedge mclk) disable iff (!rstn)
        s_status_read |-> !wb_dat_o[ST_EEE_BIT] && !wb_dat_o[ST_RXFA_BIT];
    endproperty
    a_caps_zero: assert property (p_caps_zero) // R3 R4
        else $error("capability zeros set");

    property p_status_reserved;
        @(posedge mclk) disable iff (!rstn)
        s_status_read |-> wb_dat_o[WB_DW-1:ST_OAM_BIT+1] == '0
                       && wb_dat_o[ST_LP_BIT-1:ST_POL_BIT+1] == '0;
    endproperty
    a_status_reserved: assert property (p_status_reserved) // R12
        else $error("status reserved bits nonzero");

    property p_train_reserved;
        @(posedge mclk) disable iff (!rstn)
        s_train_read |-> (wb_dat_o[REG_W-1:0] & ~TR_WMASK) == '0
                      && wb_dat_o[WB_DW-1:REG_W] == '0;
    endproperty
    a_train_reserved: assert property (p_train_reserved) // R12
        else $error("training reserved bits nonzero");

    property p_pol_live;
        @(posedge mclk) disable iff (!rstn)
        s_status_read |-> wb_dat_o[ST_POL_BIT] == $past(line_s.rx_pol_inv, 1);
    endproperty
    a_pol_live: assert property (p_pol_live) // R6
        else $error("polarity bit stale");

    property p_fault_live;
        @(posedge mclk) disable iff (!rstn)
        s_status_read |-> wb_dat_o[ST_FAULT_BIT] == $past(line_s.rx_fault, 1);
    endproperty
    a_fault_live: assert property (p_fault_live) // R7
        else $error("fault bit stale");

    property p_user_write;
        @(posedge mclk) disable iff (!rstn)
        s_train_write |=> adv_o.user == $past(wb_dat_i[TR_USER_LSB +: TR_USER_W]);
    endproperty
    a_user_write: assert property (p_user_write) // R9
        else $error("user field not written");

    property p_oam_write;
        @(posedge mclk) disable iff (!rstn)
        s_train_write |=> adv_o.oam_en == $past(wb_dat_i[TR_OAM_BIT]);
    endproperty
    a_oam_write: assert property (p_oam_write) // R10
        else $error("maintenance enable not written");

    property p_eee_write;
        @(posedge mclk) disable iff (!rstn)
        s_train_write |=> adv_o.eee_en == $past(wb_dat_i[TR_EEE_BIT]);
    endproperty
    a_eee_write: assert property (p_eee_write) // R11
        else $error("efficient enable not written");

    property p_link_drop;
        @(posedge mclk) disable iff (!rstn)
        (ce && !line_s.link_up) |=> !q.link_lat;
    endproperty
    a_link_drop: assert property (p_link_drop) // R13
        else $error("link bit not latched low");

    property p_link_hold;
        @(posedge mclk) disable iff (!rstn)
        (!q.link_lat && !(rd_acc && idx == LIDX_STATUS)) |=> !q.link_lat;
    endproperty
    a_link_hold: assert property (p_link_hold) // R13 R8
        else $error("link bit rose without a read");

    property p_ack_pulse;
        @(posedge mclk) disable iff (!rstn)
        (ce && wb_ack_o) |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");

    // a request seen while idle is answered in the very next cycle
    property p_ack_answer;
        @(posedge mclk) disable iff (!rstn)
        (ce && req && q.bus == BUS_IDLE) |=> (wb_ack_o || !req);
    endproperty
    a_ack_answer: assert property (p_ack_answer)
        else $error("ack missing after wait state");

    // every detected event lands in its sticky flag, even during a clear
    property p_ev_sticky;
        @(posedge mclk) disable iff (!rstn)
        (ce && |ev_set) |=> (irq_stat & $past(ev_set)) == $past(ev_set);
    endproperty
    a_ev_sticky: assert property (p_ev_sticky)
        else $error("event flag not set");

    // a write of ones clears the flags when no new event competes
    property p_ev_clear;
        @(posedge mclk) disable iff (!rstn)
        (ce && |ev_clr && ev_set == '0) |=> (irq_stat & $past(ev_clr)) == '0;
    endproperty
    a_ev_clear: assert property (p_ev_clear)
        else $error("event flag not cleared");

endmodule // pst_regs

// [pst_sticky.sv]
`timescale 1ns/100ps
module pst_sticky
    import pst_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         rstn,
    input  wire logic         ce,
    input  wire logic [W-1:0] set_i,
    input  wire logic [W-1:0] clr_i,
    output logic      [W-1:0] flag_o
);
    // ----------------------------------------------------------------
    // sticky flags, write one to clear; a set in the clear cycle wins
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [W-1:0] flag;  // held events
    } pst_sticky_st_t;

    pst_sticky_st_t q;
    pst_sticky_st_t d;

    // set has priority so no event is lost
    always_comb begin
        d      = q;
        d.flag = (q.flag & ~clr_i) | set_i;
    end

    // state register
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign flag_o = q.flag;
endmodule // pst_sticky

// [pst_sync.sv]
`timescale 1ns/100ps
module pst_sync
    import pst_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         rstn,
    input  wire logic         ce,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    // ----------------------------------------------------------------
    // two stage synchroniser; stage one is read by stage two only
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [W-1:0] s1;  // metastable stage
        logic [W-1:0] s2;  // settled stage
    } pst_sync_st_t;

    pst_sync_st_t q;
    pst_sync_st_t d;

    // next state: shift one stage
    always_comb begin
        d    = q;
        d.s1 = async_i;
        d.s2 = q.s1;
    end

    // state register, frozen while ce is low
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign sync_o = q.s2;
endmodule // pst_sync

// [tb_pst_regs.sv]
`timescale 1ns/100ps
module tb_pst_regs
    import pst_pkg::*;
;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic             mclk = 1'b0;  // 200 MHz system clock
    logic             rstn = 1'b0;  // held low for the first three edges
    logic             ce   = 1'b1;  // clock enable, dropped once to test freeze
    logic             cyc  = 1'b0;  // bus cycle
    logic             stb  = 1'b0;  // bus strobe
    logic             we   = 1'b0;  // write enable
    logic [WB_AW-1:0] adr  = '0;    // byte address
    logic [WB_SW-1:0] sel  = '0;    // byte lanes
    logic [WB_DW-1:0] wdat = '0;    // write data
    logic [WB_DW-1:0] rdat;         // read data
    logic             ack;          // slave answer
    pst_line_t        line = '0;    // receive side levels
    pst_adv_t         adv;          // training advertise values
    logic             irq;          // level interrupt
    int               fail_count = 0;
    int               num_checks = 0;

    // byte addresses once the space nibble is dropped
    localparam logic [WB_AW-1:0] A_ST = 14'h2404;
    localparam logic [WB_AW-1:0] A_TR = 14'h2408;
    localparam logic [WB_AW-1:0] A_IS = 14'h2440;
    localparam logic [WB_AW-1:0] A_IM = 14'h2444;
    localparam logic [WB_AW-1:0] A_UN = 14'h2410;  // no register here

    always #2.5 mclk = ~mclk;

    pst_regs i_dut (
        .mclk     (mclk),
        .rstn     (rstn),
        .ce       (ce),
        .wb_cyc_i (cyc),
        .wb_stb_i (stb),
        .wb_we_i  (we),
        .wb_adr_i (adr),
        .wb_sel_i (sel),
        .wb_dat_i (wdat),
        .wb_dat_o (rdat),
        .wb_ack_o (ack),
        .line_i   (line),
        .adv_o    (adv),
        .irq_o    (irq)
    );

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic finish_test;
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("unexpected %s exp %h got %h", name, exp, got);
            fail_count++;
        end
    endtask

    // one classic cycle; ack and data are taken at the rising edge, before the dut updates
    task automatic bus(input logic w, input logic [WB_AW-1:0] a, input logic [WB_SW-1:0] s,
                       input logic [WB_DW-1:0] d, output logic [WB_DW-1:0] r);
        int n;
        n = 0;
        r = '0;
        @(posedge mclk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= s;
        wdat <= d;
        @(posedge mclk);
        while (ack !== 1'b1 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        if (ack !== 1'b1) begin
            $display("unexpected ack exp 1 got %b", ack);
            fail_count++;
            finish_test;
        end else begin
            r = rdat;
            cyc <= 1'b0;
            stb <= 1'b0;
            we  <= 1'b0;
        end
    endtask

    // upper half of the word is all ones: it must never land anywhere
    task automatic wr(input logic [WB_AW-1:0] a, input logic [15:0] d,
                      input logic [WB_SW-1:0] s = 4'h3);
        logic [WB_DW-1:0] r;
        bus(1'b1, a, s, {16'hFFFF, d}, r);
    endtask

    task automatic rdchk(input string name, input logic [WB_AW-1:0] a, input logic [31:0] exp);
        logic [WB_DW-1:0] r;
        bus(1'b0, a, 4'hF, 32'h0, r);
        chk(name, exp, r);
    endtask

    // line change, then the two synchronizer edges plus margin
    task automatic setl(input pst_line_t v);
        @(posedge mclk);
        line <= v;
        repeat (4) @(posedge mclk);
    endtask

    task automatic irqchk(input logic exp);
        @(negedge mclk);
        chk("irq", {31'h0, exp}, {31'h0, irq});
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rdchk("status", A_ST, {16'h0, ST_RESET});
        rdchk("training", A_TR, {16'h0, TR_RESET});
        chk("adv", 32'h002, {23'h0, adv});
        rdchk("irq mask", A_IM, 32'h0);
        irqchk(1'b0);
    endtask

    task automatic t_train;
        wr(A_TR, 16'hFFFF);
        rdchk("training", A_TR, {16'h0, TR_WMASK});
        chk("adv", 32'h1FF, {23'h0, adv});
        wr(A_TR, 16'h0000, 4'h1);
        rdchk("training", A_TR, 32'h0700);
        chk("adv", 32'h1C0, {23'h0, adv});
        wr(A_TR, 16'h0552);
        rdchk("training", A_TR, 32'h0552);
        chk("adv", 32'h156, {23'h0, adv});
    endtask

    // also raises every interrupt event: fault rise, polarity change, link drop
    task automatic t_status;
        setl(3'b011);
        rdchk("status", A_ST, 32'h0906);
        setl(3'b111);
        rdchk("status", A_ST, 32'h0906);
        rdchk("status", A_ST, 32'h0907);
        wr(A_ST, 16'hFFFF);
        rdchk("status", A_ST, 32'h0907);
        setl(3'b011);
        setl(3'b111);
        rdchk("status", A_ST, 32'h0906);
        rdchk("status", A_ST, 32'h0907);
        setl(3'b101);
        rdchk("status", A_ST, 32'h0905);
        setl(3'b100);
        rdchk("status", A_ST, 32'h0901);
    endtask

    task automatic t_irq;
        rdchk("irq status", A_IS, 32'h7);
        irqchk(1'b0);
        wr(A_IM, 16'h0001);
        irqchk(1'b1);
        wr(A_IS, 16'h0001);
        irqchk(1'b0);
        rdchk("irq status", A_IS, 32'h6);
        wr(A_IM, 16'h0007);
        irqchk(1'b1);
        wr(A_IS, 16'h0006);
        irqchk(1'b0);
        rdchk("irq status", A_IS, 32'h0);
    endtask

    task automatic t_unmapped;
        rdchk("unmapped", A_UN, 32'h0);
        wr(A_UN, 16'hFFFF);
        rdchk("unmapped", A_UN, 32'h0);
        rdchk("training", A_TR, 32'h0552);
    endtask

    // freeze: a link drop during ce low is only seen once ce returns
    task automatic t_freeze;
        @(posedge mclk);
        ce   <= 1'b0;
        line <= 3'b000;
        repeat (4) @(posedge mclk);
        irqchk(1'b0);
        @(posedge mclk);
        ce <= 1'b1;
        repeat (4) @(posedge mclk);
        irqchk(1'b1);
        rdchk("status", A_ST, 32'h0900);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        t_reset;
        t_train;
        t_status;
        t_irq;
        t_unmapped;
        t_freeze;
        finish_test;
    end
endmodule // tb_pst_regs
